// ### autoreload_pwm_timer.v
/*
  8-bit auto-reload PWM timer with prescaler, four PWM channels,
  overflow time base and two input capture channels.
  Assumes a byte register port synchronous to mclk, with read data one
  cycle after the read strobe; the external clock pin is treated as a
  synchronous input sampled on mclk, the capture pins pass two synchronizer flops outside halt.
*/
`timescale 1ns/1ns
`include "autoreload_pwm_timer_map.vh"

module autoreload_pwm_timer #(
  parameter CHANNELS = 4,
  parameter CAPTURES = 2
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // Power state
  input wire haltMode,
  // External clock pin
  input wire extClockPin,
  // PWM pins
  output wire [CHANNELS-1:0] pwmOutputPin,
  output wire [CHANNELS-1:0] pwmOutEnable,
  // Capture pins
  input wire [CAPTURES-1:0] captureInputPin,
  // Interrupts and wake
  output wire overflowIrq,
  output wire [CAPTURES-1:0] captureIrq,
  output wire haltWake
);

  // ==========================================================
  // Register decode
  function [7:0] dutyOffset;
    input integer ch;
    begin
      dutyOffset = `OFS_DUTY0 - ch[7:0];
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Register strobes
  wire wrCsr;
  wire wrCar;
  wire wrArr;
  wire wrPwmCtl;
  wire wrCapCsr;
  wire rdCsr;
  wire rdCap1;
  wire rdCap2;
  assign wrCsr = regWrite && hit(regAddr, `OFS_CSR);
  assign wrCar = regWrite && hit(regAddr, `OFS_CAR);
  assign wrArr = regWrite && hit(regAddr, `OFS_ARR);
  assign wrPwmCtl = regWrite && hit(regAddr, `OFS_PWMCTL);
  assign wrCapCsr = regWrite && hit(regAddr, `OFS_CAPCSR);
  assign rdCsr = regRead && hit(regAddr, `OFS_CSR);
  assign rdCap1 = regRead && hit(regAddr, `OFS_CAP1);
  assign rdCap2 = regRead && hit(regAddr, `OFS_CAP2);

  // ==========================================================
  // Control state
  reg extClockSel_reg;
  reg [2:0] prescaleSel_reg;
  reg counterRun_reg;
  reg overflowIrqEnable_reg;
  reg overflowFlag_reg;
  reg [7:0] reloadValue_reg;
  reg [7:0] pwmCtl_reg;
  reg [1:0] captureEdgeSel_reg;
  reg [1:0] captureIrqEnable_reg;
  wire [CAPTURES-1:0] captureFlag;
  reg [7:0] counter_reg;
  reg [`PSC_W-1:0] prescaler_reg;
  reg extClockLast_reg;

  // ==========================================================
  // Prescaler and counter tick
  wire extRise;
  wire inputTick;
  wire [`PSC_W:0] pscNext;
  wire [`PSC_W:0] pscMask;
  wire tapReady;
  wire countTick;
  wire overflow;
  wire forceReload;
  wire [7:0] counterInc;
  assign extRise = extClockPin && !extClockLast_reg;
  assign inputTick = extClockSel_reg ? extRise : 1'b1;
  assign pscNext = {1'b0, prescaler_reg} + {{`PSC_W{1'b0}}, 1'b1};
  assign pscMask = ({{`PSC_W{1'b0}}, 1'b1} << prescaleSel_reg) - 1'b1;
  // Tick when all bits below the selected tap are set
  assign tapReady = ((prescaler_reg & pscMask[`PSC_W-1:0]) == pscMask[`PSC_W-1:0]);
  assign countTick = counterRun_reg && inputTick && tapReady;
  assign overflow = countTick && (counter_reg == `CNT_MAX);
  assign forceReload = wrCsr && regWrData[`CSR_FRL] && regWrData[`CSR_RUN];
  assign counterInc = counter_reg + 8'h01;

  always @(posedge mclk) begin
    if (reset) begin
      prescaler_reg <= {`PSC_W{1'b0}};
      counter_reg <= `RST_BYTE;
      extClockLast_reg <= 1'b0;
    end else begin
      extClockLast_reg <= extClockPin;
      if (wrCar) begin
        counter_reg <= regWrData;
        prescaler_reg <= {`PSC_W{1'b0}};
      end else if (forceReload) begin
        counter_reg <= reloadValue_reg;
        prescaler_reg <= {`PSC_W{1'b0}};
      end else if (counterRun_reg && inputTick) begin
        prescaler_reg <= pscNext[`PSC_W-1:0];
        if (overflow) begin
          counter_reg <= reloadValue_reg;
        end else if (countTick) begin
          counter_reg <= counterInc;
        end
      end
    end
  end

  // ==========================================================
  // Control/status, reload and PWM control registers
  always @(posedge mclk) begin
    if (reset) begin
      extClockSel_reg <= 1'b0;
      prescaleSel_reg <= 3'h0;
      counterRun_reg <= 1'b0;
      overflowIrqEnable_reg <= 1'b0;
      overflowFlag_reg <= 1'b0;
      reloadValue_reg <= `RST_BYTE;
      pwmCtl_reg <= `RST_BYTE;
    end else begin
      if (wrCsr) begin
        extClockSel_reg <= regWrData[`CSR_EXTCLK];
        prescaleSel_reg <= regWrData[`CSR_PSC_HI:`CSR_PSC_LO];
        counterRun_reg <= regWrData[`CSR_RUN];
        overflowIrqEnable_reg <= regWrData[`CSR_OIE];
      end
      // Set wins over the read clear
      if (overflow) begin
        overflowFlag_reg <= 1'b1;
      end else if (rdCsr) begin
        overflowFlag_reg <= 1'b0;
      end
      if (wrArr) begin
        reloadValue_reg <= regWrData;
      end
      if (wrPwmCtl) begin
        pwmCtl_reg <= regWrData;
      end
    end
  end

  // ==========================================================
  // Overflow request
  assign overflowIrq = overflowFlag_reg && overflowIrqEnable_reg;

  // ==========================================================
  // PWM channels
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : pwmChan
      reg [7:0] dutyBuffer_reg;
      reg [7:0] hiddenCompare_reg;
      reg active_reg;
      wire matchNext;
      assign matchNext = countTick && (counterInc == hiddenCompare_reg);
      always @(posedge mclk) begin
        if (reset) begin
          dutyBuffer_reg <= `RST_BYTE;
          hiddenCompare_reg <= `RST_BYTE;
          active_reg <= 1'b0;
        end else begin
          if (regWrite && hit(regAddr, dutyOffset(ch))) begin
            dutyBuffer_reg <= regWrData;
          end
          if (!haltMode) begin
            if (overflow) begin
              hiddenCompare_reg <= dutyBuffer_reg;
              active_reg <= 1'b1;
            end else if (matchNext) begin
              active_reg <= 1'b0;
            end
          end
        end
      end
      // Polarity applies immediately to the level
      assign pwmOutputPin[ch] = pwmOutEnable[ch] &&
        (active_reg ? !pwmCtl_reg[ch] : pwmCtl_reg[ch]);
      assign pwmOutEnable[ch] = pwmCtl_reg[ch+4];
    end
  endgenerate

  // ==========================================================
  // Input capture channels
  function edgeSeen;
    input rising;
    input now;
    input last;
    begin
      if (rising)
        edgeSeen = now && !last;
      else
        edgeSeen = !now && last;
    end
  endfunction

  genvar cp;
  generate
    for (cp = 0; cp < CAPTURES; cp = cp + 1) begin : capChan
      reg sync1_reg;
      reg sync2_reg;
      reg syncLast_reg;
      reg pinLast_reg;
      reg flag_reg;
      reg [7:0] value_reg;
      wire syncEdge;
      wire pinEdge;
      wire rdThis;
      assign syncEdge = edgeSeen(captureEdgeSel_reg[cp], sync2_reg, syncLast_reg);
      assign pinEdge = edgeSeen(captureEdgeSel_reg[cp], captureInputPin[cp], pinLast_reg);
      assign rdThis = (cp == 0) ? rdCap1 : rdCap2;
      always @(posedge mclk) begin
        if (reset) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          syncLast_reg <= 1'b0;
          pinLast_reg <= 1'b0;
          value_reg <= `RST_BYTE;
          flag_reg <= 1'b0;
        end else begin
          sync1_reg <= captureInputPin[cp];
          sync2_reg <= sync1_reg;
          syncLast_reg <= sync2_reg;
          pinLast_reg <= captureInputPin[cp];
          if (!haltMode && syncEdge && !flag_reg) begin
            value_reg <= counter_reg;
            flag_reg <= 1'b1;
          end else if (haltMode && pinEdge) begin
            flag_reg <= 1'b1;
          end else if (rdThis) begin
            flag_reg <= 1'b0;
          end
        end
      end
      assign captureFlag[cp] = flag_reg;
      assign captureIrq[cp] = flag_reg && captureIrqEnable_reg[cp];
    end
  endgenerate

  // ==========================================================
  // Wake request in halt
  assign haltWake = haltMode && |captureIrq;

  // ==========================================================
  // Capture control register
  always @(posedge mclk) begin
    if (reset) begin
      captureEdgeSel_reg <= 2'h0;
      captureIrqEnable_reg <= 2'h0;
    end else if (wrCapCsr) begin
      captureEdgeSel_reg <= regWrData[5:4];
      captureIrqEnable_reg <= regWrData[3:2];
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  reg [7:0] rdMux;
  always @* begin
    rdMux = 8'h00;
    if (regAddr == `OFS_CSR) begin
      rdMux = {extClockSel_reg, prescaleSel_reg, counterRun_reg, 1'b0,
               overflowIrqEnable_reg, overflowFlag_reg};
    end else if (regAddr == `OFS_CAR) begin
      rdMux = counter_reg;
    end else if (regAddr == `OFS_ARR) begin
      rdMux = reloadValue_reg;
    end else if (regAddr == `OFS_PWMCTL) begin
      rdMux = pwmCtl_reg;
    end else if (regAddr == `OFS_DUTY0) begin
      rdMux = pwmChan[0].dutyBuffer_reg;
    end else if (regAddr == `OFS_DUTY1) begin
      rdMux = pwmChan[1].dutyBuffer_reg;
    end else if (regAddr == `OFS_DUTY2) begin
      rdMux = pwmChan[2].dutyBuffer_reg;
    end else if (regAddr == `OFS_DUTY3) begin
      rdMux = pwmChan[3].dutyBuffer_reg;
    end else if (regAddr == `OFS_CAPCSR) begin
      rdMux = {2'b00, captureEdgeSel_reg, captureIrqEnable_reg, captureFlag};
    end else if (regAddr == `OFS_CAP1) begin
      rdMux = capChan[0].value_reg;
    end else if (regAddr == `OFS_CAP2) begin
      rdMux = capChan[1].value_reg;
    end
  end

  // ==========================================================
  // Read data register
  always @(posedge mclk) begin
    if (reset) begin
      regRdData <= `RST_BYTE;
    end else if (regRead) begin
      regRdData <= rdMux;
    end
  end

endmodule

// ### autoreload_pwm_timer_map.vh
/*
  Register offsets, field positions and reset values of the auto-reload
  PWM timer. Included by the timer module, its checker and its bench.
*/
`ifndef AUTORELOAD_PWM_TIMER_MAP_VH
`define AUTORELOAD_PWM_TIMER_MAP_VH

// ==========================================================
// Register offsets
`define OFS_DUTY3 8'h31
`define OFS_DUTY2 8'h32
`define OFS_DUTY1 8'h33
`define OFS_DUTY0 8'h34
`define OFS_PWMCTL 8'h35
`define OFS_CSR 8'h36
`define OFS_CAR 8'h37
`define OFS_ARR 8'h38
`define OFS_CAPCSR 8'h39
`define OFS_CAP1 8'h3A
`define OFS_CAP2 8'h3B

// ==========================================================
// Control/status fields
`define CSR_EXTCLK 7
`define CSR_PSC_HI 6
`define CSR_PSC_LO 4
`define CSR_RUN 3
`define CSR_FRL 2
`define CSR_OIE 1
`define CSR_OVF 0

// ==========================================================
// Reset values and widths
`define RST_BYTE 8'h00
`define PSC_W 7
`define CNT_MAX 8'hFF

`endif

// ### autoreload_pwm_timer_monitor.sv
/*
  Port checker for the auto-reload PWM timer.
  Assumes the register map header and a bind to every timer instance.
*/
`timescale 1ns/1ns
`include "autoreload_pwm_timer_map.vh"
module autoreload_pwm_timer_monitor #(
  parameter CHANNELS = 4,
  parameter CAPTURES = 2
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  // Pins and requests
  input wire haltMode,
  input wire [CHANNELS-1:0] pwmOutputPin,
  input wire [CHANNELS-1:0] pwmOutEnable,
  input wire overflowIrq,
  input wire [CAPTURES-1:0] captureIrq,
  input wire haltWake
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire csrRd = regRead && regAddr == `OFS_CSR;
  wire csrWr = regWrite && regAddr == `OFS_CSR;
  // ==========================================================
  // Properties
  property p_en;
    regWrite && regAddr == `OFS_PWMCTL |=> pwmOutEnable == $past(regWrData[7:4]);
  endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  property p_quiet;
    (pwmOutputPin & ~pwmOutEnable) == 0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("disabled pin driven");
  property p_ovhold;
    overflowIrq && !csrRd && !csrWr |=> overflowIrq;
  endproperty
  a_ovhold: assert property (p_ovhold) else $error("overflow request lost");
  property p_frl;
    csrRd |=> !regRdData[`CSR_FRL];
  endproperty
  a_frl: assert property (p_frl) else $error("reload bit read as one");
  property p_caphold;
    captureIrq[0] && !(regRead && regAddr == `OFS_CAP1)
      && !(regWrite && regAddr == `OFS_CAPCSR) |=> captureIrq[0];
  endproperty
  a_caphold: assert property (p_caphold) else $error("capture request lost");
  property p_wake;
    haltWake |-> haltMode && |captureIrq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_rst;
    $past(reset) |-> pwmOutEnable == 0 && !overflowIrq && captureIrq == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_halt;
    haltMode && $past(haltMode) && !$past(regWrite) |-> $stable(pwmOutputPin);
  endproperty
  a_halt: assert property (p_halt) else $error("pins moved in halt");
  property p_car;
    regWrite && regAddr == `OFS_CAR ##1 regRead && regAddr == `OFS_CAR
      |=> regRdData == $past(regWrData, 2);
  endproperty
  a_car: assert property (p_car) else $error("counter write lost");
endmodule

bind autoreload_pwm_timer autoreload_pwm_timer_monitor #(
  .CHANNELS(CHANNELS), .CAPTURES(CAPTURES)
) mon (
  .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .haltMode(haltMode), .pwmOutputPin(pwmOutputPin), .pwmOutEnable(pwmOutEnable),
  .overflowIrq(overflowIrq), .captureIrq(captureIrq), .haltWake(haltWake)
);

// ### autoreload_pwm_timer_test.sv
/*
  Self-checking bench for the auto-reload PWM timer.
  Assumes the pin model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`include "autoreload_pwm_timer_map.vh"
module autoreload_pwm_timer_test;
  reg mclk, reset, regWrite, regRead, haltMode;
  reg [7:0] regAddr, regWrData;
  wire [7:0] regRdData;
  wire [3:0] pwmOutputPin, pwmOutEnable;
  wire extClockPin, overflowIrq, haltWake;
  wire [1:0] captureInputPin, captureIrq;
  integer errors = 0, check_count = 0, i, r, d, n, t;
  autoreload_pwm_timer dut (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .haltMode(haltMode), .extClockPin(extClockPin), .pwmOutputPin(pwmOutputPin),
    .pwmOutEnable(pwmOutEnable), .captureInputPin(captureInputPin),
    .overflowIrq(overflowIrq), .captureIrq(captureIrq), .haltWake(haltWake)
  );
  timer_pin_model pins (.mclk(mclk), .extClockPin(extClockPin),
    .captureInputPin(captureInputPin));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ==========================================================
  // Tasks and expectations
  function [7:0] span(input integer cnt, input integer sh);
    span = cnt << sh;
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    if (regWrite) @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    chk(regRdData, e);
    @(posedge mclk);
  endtask
  task wait_pin(input logic v);
    t = 0;
    while (pwmOutputPin[0] !== v && t < 5000) begin
      @(negedge mclk);
      t++;
    end
    if (t >= 5000) errors++;
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    finish_test;
  end
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    haltMode = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    void'($urandom(97));
    for (i = 8'h30; i <= 8'h3C; i++) rd(i[7:0], 8'h00);
    for (i = 8'h31; i <= 8'h38; i++) begin
      if (i != 8'h36 && i != 8'h37) begin
        d = $urandom % 256;
        wr(i[7:0], d[7:0]);
        rd(i[7:0], d[7:0]);
      end
    end
    wr(`OFS_CSR, 8'h74);
    rd(`OFS_CSR, 8'h70);
    $display("registers done");
    d = $urandom % 256;
    wr(`OFS_CAR, d[7:0]);
    rd(`OFS_CAR, d[7:0]);
    repeat (20) @(posedge mclk);
    rd(`OFS_CAR, d[7:0]);
    $display("counter done");
    for (i = 0; i < 3; i++) begin
      r = 200 + $urandom % 50;
      d = (i == 0) ? r + 1 : r + 1 + $urandom % (255 - r);
      n = $urandom % 3;
      wr(`OFS_ARR, r[7:0]);
      wr(`OFS_DUTY0, d[7:0]);
      wr(`OFS_PWMCTL, 8'h10);
      wr(`OFS_CSR, {1'b0, n[2:0], 4'hE});
      wait_pin(1'b1);
      wait_pin(1'b0);
      wait_pin(1'b1);
      wait_pin(1'b0);
      chk(t[7:0], span(d - r, n));
      wait_pin(1'b1);
      chk(t[7:0], span(256 - d, n));
      @(posedge mclk);
    end
    chk({7'h0, overflowIrq}, 8'h01);
    wr(`OFS_CSR, 8'h02);
    rd(`OFS_CSR, 8'h03);
    rd(`OFS_CSR, 8'h02);
    $display("pwm done");
    wr(`OFS_ARR, 8'hFD);
    wr(`OFS_CSR, 8'h8E);
    rd(`OFS_CSR, 8'h8A);
    pins.ext_edges(2);
    chk({7'h0, overflowIrq}, 8'h00);
    pins.ext_edges(1);
    chk({7'h0, overflowIrq}, 8'h01);
    wr(`OFS_CSR, 8'h80);
    rd(`OFS_CSR, 8'h81);
    $display("events done");
    wr(`OFS_CAR, 8'h5A);
    wr(`OFS_CAPCSR, 8'h14);
    pins.cap_set(0, 1'b1);
    chk({6'h0, captureIrq}, 8'h01);
    wr(`OFS_CAR, 8'hA5);
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    rd(`OFS_CAPCSR, 8'h15);
    rd(`OFS_CAP1, 8'h5A);
    chk({6'h0, captureIrq}, 8'h00);
    haltMode <= 1'b1;
    pins.cap_set(0, 1'b0);
    pins.cap_set(0, 1'b1);
    chk({7'h0, haltWake}, 8'h01);
    rd(`OFS_CAP1, 8'h5A);
    haltMode <= 1'b0;
    $display("capture done");
    finish_test;
  end
endmodule

// ### timer_pin_model.sv
/*
  Far-side pin model: external clock source and capture inputs.
  Assumes the bench calls its tasks right after a rising mclk edge.
*/
`timescale 1ns/1ns
module timer_pin_model (
  // Clock
  input wire mclk,
  // Pins
  output reg extClockPin,
  output reg [1:0] captureInputPin
);
  initial begin
    extClockPin = 1'b0;
    captureInputPin = 2'b00;
  end
  // ==========================================================
  // External clock bursts, still and low between them
  task ext_edges(input integer n);
    repeat (n) begin
      @(posedge mclk) extClockPin <= 1'b1;
      repeat (2) @(posedge mclk);
      extClockPin <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  // ==========================================================
  // Capture pin level change, then settle time
  task cap_set(input integer ch, input logic lvl);
    @(posedge mclk) captureInputPin[ch] <= lvl;
    repeat (5) @(posedge mclk);
  endtask
endmodule
